// *** port_pad_mode_pullup_ctrl.v ***
/*
 Pad control for port 0 pull-ups and data, and port 1 upper-pin modes, on AXI4-Lite.
 Assumes pins, direction and peripheral sources are synchronous to aclk.
*/
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
// Overview of operation
// (RULE_01) Pull-up bit set enables that pin's pull-up
// (RULE_02) Input pin: data read returns pin level
// (RULE_03) Output pin drives its data bit value
// (RULE_04) Top mode register resets to 01, open-drain
// (RULE_05) Line 4: 00 Schmitt, 01 OD, 11 PP
// (RULE_06) Middle mode register resets to 20H
// (RULE_07) Line 3 decodes Schmitt, OD, analog, PWM, PP
// (RULE_08) Line 2 decodes Schmitt, analog, PWM, buzzer, PP
// (RULE_09) Software also enables the selected peripheral
// (RULE_10) Unavailable codes float; unused bits read zero
`timescale 1ns/100ps
`include "port_pad_consts.vh"
module port_pad_mode_pullup_ctrl
(
   // Clock and reset
   input  wire                aclk,
   input  wire                aresetn,
   // AXI4-Lite write address
   input  wire                awvalid,
   output wire                awready,
   input  wire [`ADDR_W-1:0]  awaddr,
   // AXI4-Lite write data
   input  wire                wvalid,
   output wire                wready,
   input  wire [31:0]         wdata,
   input  wire [3:0]          wstrb,
   // AXI4-Lite write response
   output wire                bvalid,
   input  wire                bready,
   output wire [1:0]          bresp,
   // AXI4-Lite read address
   input  wire                arvalid,
   output wire                arready,
   input  wire [`ADDR_W-1:0]  araddr,
   // AXI4-Lite read data
   output wire                rvalid,
   input  wire                rready,
   output wire [31:0]         rdata,
   output wire [1:0]          rresp,
   // Port 0 pads
   input  wire [7:0]          port0_pin_in,
   output wire [7:0]          port0_pin_out,
   output wire [7:0]          port0_pin_oe,
   output wire [7:0]          port0_pullup_en,
   input  wire [7:0]          port0_dir_out,
   // Port 1 pads, lines 4 to 2
   input  wire [4:2]          port1_pin_in,
   output wire [4:2]          port1_pin_out,
   output wire [4:2]          port1_pin_oe,
   input  wire [4:2]          port1_data,
   // Peripheral sources
   input  wire                pwm_four_out,
   input  wire                pwm_three_out,
   input  wire                buzzer_out,
   // Peripheral sinks
   output wire                ext_irq_nine,
   output wire                ext_irq_eight,
   output wire                analog_in_eight_sel,
   output wire                analog_in_seven_sel
);

   // Address to register select
   function [2:0] reg_sel;
      input [`ADDR_W-1:0] a;
      begin
         if (a == `OFS_P0_PULLUP)
            reg_sel = `SEL_P0_PULLUP;
         else if (a == `OFS_P0_DATA)
            reg_sel = `SEL_P0_DATA;
         else if (a == `OFS_P1_TOP_MODE)
            reg_sel = `SEL_P1_TOP_MODE;
         else if (a == `OFS_P1_MID_MODE)
            reg_sel = `SEL_P1_MID_MODE;
         else
            reg_sel = `SEL_NONE;
      end
   endfunction

   // Write channel state
   reg                aw_held_r;
   reg [`ADDR_W-1:0]  aw_addr_r;
   reg                w_held_r;
   reg [7:0]          w_byte_r;
   reg                w_lane0_r;
   reg                bvalid_r;
   reg [1:0]          bresp_r;

   // Read channel state
   reg                rvalid_r;
   reg [31:0]         rdata_r;
   reg [1:0]          rresp_r;

   // Write commit
   wire               wr_go;
   wire [2:0]         wr_sel;
   wire               wr_ok;
   wire               we_pullup;
   wire               we_data;
   wire               we_top;
   wire               we_mid;

   // Register contents
   wire [7:0]         pullup_q;
   wire [7:0]         data_q;
   wire [7:0]         top_mode_q;
   wire [7:0]         mid_mode_q;

   // Read path
   wire [2:0]         rd_sel;
   wire [7:0]         p0_read;
   reg  [7:0]         rd_byte;
   reg  [1:0]         rd_resp;

   // Port 1 decoded controls
   wire [2:0]         p1_mode [0:2];
   wire [2:0]         p1_pwm;
   wire [2:0]         p1_out;
   wire [2:0]         p1_oe;
   wire [2:0]         p1_schmitt;
   wire [2:0]         p1_analog;

   // Write address and data channels
   assign awready = ~aw_held_r & ~bvalid_r;
   assign wready  = ~w_held_r & ~bvalid_r;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         aw_addr_r <= {`ADDR_W{1'b0}};
      end
      else if (wr_go)
      begin
         aw_held_r <= 1'b0;
      end
      else if (awvalid && awready)
      begin
         aw_held_r <= 1'b1;
         aw_addr_r <= awaddr;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r  <= 1'b0;
         w_byte_r  <= 8'h00;
         w_lane0_r <= 1'b0;
      end
      else if (wr_go)
      begin
         w_held_r <= 1'b0;
      end
      else if (wvalid && wready)
      begin
         w_held_r  <= 1'b1;
         w_byte_r  <= wdata[7:0];
         w_lane0_r <= wstrb[0];
      end
   end

   // Commit once both halves are held
   assign wr_go     = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_sel    = reg_sel(aw_addr_r);
   assign wr_ok     = (wr_sel != `SEL_NONE);
   assign we_pullup = wr_go & w_lane0_r & (wr_sel == `SEL_P0_PULLUP);
   assign we_data   = wr_go & w_lane0_r & (wr_sel == `SEL_P0_DATA);
   assign we_top    = wr_go & w_lane0_r & (wr_sel == `SEL_P1_TOP_MODE);
   assign we_mid    = wr_go & w_lane0_r & (wr_sel == `SEL_P1_MID_MODE);

   // Write response
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= `RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bready)
      begin
         bvalid_r <= 1'b0;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp  = bresp_r;

   // Software registers
   mode_reg8
   #(
      .RESET_VAL (`RST_P0_PULLUP),
      .WR_MASK   (`MSK_P0_PULLUP)
   )
   u_pullup
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (we_pullup),
      .wr_data (w_byte_r),
      .q_r     (pullup_q)
   );

   mode_reg8
   #(
      .RESET_VAL (`RST_P0_DATA),
      .WR_MASK   (`MSK_P0_DATA)
   )
   u_data
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (we_data),
      .wr_data (w_byte_r),
      .q_r     (data_q)
   );

   mode_reg8
   #(
      .RESET_VAL (`RST_P1_TOP_MODE), // RULE_04
      .WR_MASK   (`MSK_P1_TOP_MODE)
   )
   u_top_mode
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (we_top),
      .wr_data (w_byte_r),
      .q_r     (top_mode_q)
   );

   mode_reg8
   #(
      .RESET_VAL (`RST_P1_MID_MODE), // RULE_06
      .WR_MASK   (`MSK_P1_MID_MODE)
   )
   u_mid_mode
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (we_mid),
      .wr_data (w_byte_r),
      .q_r     (mid_mode_q)
   );

   // Port 0 pads
   assign port0_pullup_en = pullup_q; // RULE_01

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_port0
         assign port0_pin_oe[g]  = port0_dir_out[g]; // RULE_03
         assign port0_pin_out[g] = port0_dir_out[g] & data_q[g]; // RULE_03
         assign p0_read[g]       = port0_dir_out[g] ? data_q[g] : port0_pin_in[g]; // RULE_02
      end
   endgenerate

   // Port 1 mode fields, index 0 is line 4
   assign p1_mode[0] = {1'b0, top_mode_q[`LINE4_MODE_LSB+1:`LINE4_MODE_LSB]};
   assign p1_mode[1] = mid_mode_q[`LINE3_MODE_LSB+2:`LINE3_MODE_LSB];
   assign p1_mode[2] = mid_mode_q[`LINE2_MODE_LSB+2:`LINE2_MODE_LSB];
   assign p1_pwm     = {pwm_three_out, pwm_four_out, 1'b0};

   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_port1
         pin_mode_decode
         #(
            .KIND ((g == 0) ? `KIND_LINE4 : ((g == 1) ? `KIND_LINE3 : `KIND_LINE2))
         )
         u_dec
         (
            .mode       (p1_mode[g]),
            .data_bit   (port1_data[4-g]),
            .alt_pwm    (p1_pwm[g]),
            .alt_buz    (buzzer_out),
            .pin_out    (p1_out[g]),
            .pin_oe     (p1_oe[g]),
            .schmitt_en (p1_schmitt[g]),
            .analog_en  (p1_analog[g])
         );
         assign port1_pin_out[4-g] = p1_out[g];
         assign port1_pin_oe[4-g]  = p1_oe[g];
      end
   endgenerate

   // Peripheral hook-ups, valid only when the peripheral is enabled too
   assign ext_irq_nine        = p1_schmitt[1] & port1_pin_in[3]; // RULE_07
   assign ext_irq_eight       = p1_schmitt[2] & port1_pin_in[2]; // RULE_08
   assign analog_in_eight_sel = p1_analog[1]; // RULE_07
   assign analog_in_seven_sel = p1_analog[2]; // RULE_08

   // Read address and data
   assign arready = ~rvalid_r;
   assign rd_sel  = reg_sel(araddr);

   always @*
   begin
      rd_byte = 8'h00;
      rd_resp = `RESP_OKAY;
      if (rd_sel == `SEL_P0_PULLUP)
      begin
         rd_byte = pullup_q;
      end
      else if (rd_sel == `SEL_P0_DATA)
      begin
         rd_byte = p0_read; // RULE_02
      end
      else if (rd_sel == `SEL_P1_TOP_MODE)
      begin
         rd_byte = top_mode_q; // RULE_10
      end
      else if (rd_sel == `SEL_P1_MID_MODE)
      begin
         rd_byte = mid_mode_q; // RULE_10
      end
      else
      begin
         rd_resp = `RESP_SLVERR;
      end
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= {24'h00_0000, rd_byte};
         rresp_r  <= rd_resp;
      end
      else if (rready)
      begin
         rvalid_r <= 1'b0;
      end
   end

   assign rvalid = rvalid_r;
   assign rdata  = rdata_r;
   assign rresp  = rresp_r;

endmodule // port_pad_mode_pullup_ctrl

// *** port_pad_consts.vh ***
/*
 Register map, field layout, reset values and mode codes of the port pad control block.
 Assumes inclusion by bare name from the design, checker and bench files.
*/
`ifndef PORT_PAD_CONSTS_VH
`define PORT_PAD_CONSTS_VH

// Byte addresses on the register bus
`define ADDR_W              8
`define OFS_P0_PULLUP       8'h00
`define OFS_P0_DATA         8'h04
`define OFS_P1_TOP_MODE     8'h08
`define OFS_P1_MID_MODE     8'h0c

// Register select codes
`define SEL_NONE            3'h0
`define SEL_P0_PULLUP       3'h1
`define SEL_P0_DATA         3'h2
`define SEL_P1_TOP_MODE     3'h3
`define SEL_P1_MID_MODE     3'h4

// Reset values
`define RST_P0_PULLUP       8'h00
`define RST_P0_DATA         8'h00
`define RST_P1_TOP_MODE     8'h01
`define RST_P1_MID_MODE     8'h20

// Writable bit masks
`define MSK_P0_PULLUP       8'hff
`define MSK_P0_DATA         8'hff
`define MSK_P1_TOP_MODE     8'h03
`define MSK_P1_MID_MODE     8'hfc

// Mode field positions
`define LINE4_MODE_LSB      0
`define LINE3_MODE_LSB      5
`define LINE2_MODE_LSB      2

// Decoder kinds
`define KIND_LINE4          2'h0
`define KIND_LINE3          2'h1
`define KIND_LINE2          2'h2

// Mode codes
`define MODE_SCHMITT        3'h0
`define MODE_OPEN_DRAIN     3'h1
`define MODE_ANALOG         3'h2
`define MODE_ALT_PWM        3'h3
`define MODE_BUZZER         3'h5
`define MODE_PUSH_PULL      3'h7
`define MODE2_PUSH_PULL     3'h3

// Bus responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// *** mode_reg8.v ***
/*
 Eight-bit software register with a write mask and a reset value.
 Assumes a synchronous active-low reset and a one-cycle write strobe.
*/
`timescale 1ns/100ps
module mode_reg8
#(
   parameter [7:0] RESET_VAL = 8'h00,
   parameter [7:0] WR_MASK   = 8'hff
)
(
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Write port
   input  wire       wr_en,
   input  wire [7:0] wr_data,
   // Stored value
   output reg  [7:0] q_r
);

   wire [7:0] q_nxt;

   // Unused bits held at zero
   assign q_nxt = wr_data & WR_MASK; // RULE_10

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q_r <= RESET_VAL;
      end
      else if (wr_en)
      begin
         q_r <= q_nxt;
      end
   end

endmodule // mode_reg8

// *** pin_mode_decode.v ***
/*
 Decodes a port 1 pin mode field into pad drive, input and analog controls.
 Assumes the mode field comes from a register and alternate sources are synchronous.
*/
`timescale 1ns/100ps
`include "port_pad_consts.vh"
module pin_mode_decode
#(
   parameter [1:0] KIND = `KIND_LINE4
)
(
   // Mode and sources
   input  wire [2:0] mode,
   input  wire       data_bit,
   input  wire       alt_pwm,
   input  wire       alt_buz,
   // Pad controls
   output wire       pin_out,
   output wire       pin_oe,
   output wire       schmitt_en,
   output wire       analog_en
);

   // Returns {oe, out, schmitt, analog}
   function [3:0] decode;
      input [1:0] kind;
      input [2:0] m;
      input       d;
      input       pwm;
      input       buz;
      begin
         decode = 4'h0; // RULE_10
         if (kind == `KIND_LINE4)
         begin
            if (m == `MODE_SCHMITT)
               decode = 4'b0010; // RULE_05
            else if (m == `MODE_OPEN_DRAIN)
               decode = {~d, 3'b000}; // RULE_05
            else if (m == `MODE2_PUSH_PULL)
               decode = {1'b1, d, 2'b00}; // RULE_05
         end
         else if (kind == `KIND_LINE3)
         begin
            if (m[2])
               decode = {1'b1, d, 2'b00}; // RULE_07
            else if (m == `MODE_SCHMITT)
               decode = 4'b0010; // RULE_07
            else if (m == `MODE_OPEN_DRAIN)
               decode = {~d, 3'b000}; // RULE_07
            else if (m == `MODE_ANALOG)
               decode = 4'b0001; // RULE_07
            else
               decode = {1'b1, pwm, 2'b00}; // RULE_07
         end
         else
         begin
            if (m == `MODE_SCHMITT)
               decode = 4'b0010; // RULE_08
            else if (m == `MODE_ANALOG)
               decode = 4'b0001; // RULE_08
            else if (m == `MODE_ALT_PWM)
               decode = {1'b1, pwm, 2'b00}; // RULE_08
            else if (m == `MODE_BUZZER)
               decode = {1'b1, buz, 2'b00}; // RULE_08
            else if (m == `MODE_PUSH_PULL)
               decode = {1'b1, d, 2'b00}; // RULE_08
         end
      end
   endfunction

   wire [3:0] ctl;

   assign ctl        = decode(KIND, mode, data_bit, alt_pwm, alt_buz);
   assign pin_oe     = ctl[3];
   assign pin_out    = ctl[2];
   assign schmitt_en = ctl[1];
   assign analog_en  = ctl[0];

endmodule // pin_mode_decode

// *** pad_ctrl_props.sv ***
/* Concurrent checks on the pad control block's ports.
 Assumes one clock, aclk, and a synchronous active-low reset. */
`timescale 1ns/100ps
`include "port_pad_consts.vh"
module pad_ctrl_props
(
   // Clock and reset
   input wire               aclk,
   input wire               aresetn,
   // Register bus
   input wire               awvalid,
   input wire               awready,
   input wire [`ADDR_W-1:0] awaddr,
   input wire               wvalid,
   input wire               wready,
   input wire [31:0]        wdata,
   input wire [3:0]         wstrb,
   input wire               bvalid,
   input wire [1:0]         bresp,
   input wire               arvalid,
   input wire               arready,
   input wire               rvalid,
   input wire [31:0]        rdata,
   // Pads
   input wire [7:0]         port0_pin_out,
   input wire [7:0]         port0_pin_oe,
   input wire [7:0]         port0_pullup_en,
   input wire [7:0]         port0_dir_out,
   input wire [4:2]         port1_pin_in,
   input wire [4:2]         port1_pin_oe,
   input wire [4:2]         port1_data,
   // Sinks
   input wire               ext_irq_nine,
   input wire               ext_irq_eight,
   input wire               analog_in_eight_sel
);
wire wr_go = awvalid & awready & wvalid & wready;
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
a_oe_dir:
   assert property (port0_pin_oe == port0_dir_out) else $error("oe not dir");
a_out_masked:
   assert property ((port0_pin_out & ~port0_dir_out) == 8'h00) else $error("out on input");
a_reset_modes:
   assert property ($rose(aresetn) |-> port1_pin_oe == {~port1_data[4:3], 1'b0})
   else $error("reset modes");
a_pullup_wr:
   assert property (wr_go && awaddr == `OFS_P0_PULLUP && wstrb[0]
      |-> ##2 port0_pullup_en == $past(wdata[7:0], 2)) else $error("pullup");
a_irq_nine:
   assert property (ext_irq_nine |-> port1_pin_in[3] && !port1_pin_oe[3]) else $error("irq9");
a_irq_eight:
   assert property (ext_irq_eight |-> port1_pin_in[2] && !port1_pin_oe[2]) else $error("irq8");
a_analog_eight:
   assert property (analog_in_eight_sel |-> !port1_pin_oe[3] && !ext_irq_nine)
   else $error("analog");
a_read_next:
   assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0) else $error("read");
a_write_resp:
   assert property (wr_go |-> ##2 bvalid) else $error("bresp late");
a_bad_addr:
   assert property (wr_go && awaddr > `OFS_P1_MID_MODE |-> ##2 bresp == `RESP_SLVERR)
   else $error("unmapped");
endmodule // pad_ctrl_props

bind port_pad_mode_pullup_ctrl pad_ctrl_props u_props (.aclk, .aresetn, .awvalid, .awready,
   .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bresp, .arvalid, .arready, .rvalid,
   .rdata, .port0_pin_out, .port0_pin_oe, .port0_pullup_en, .port0_dir_out, .port1_pin_in,
   .port1_pin_oe, .port1_data, .ext_irq_nine, .ext_irq_eight, .analog_in_eight_sel);

// *** board_pins.sv ***
/* Board circuitry on the port pins: far-end drivers and pull-ups.
 Assumes pad controls are settled combinationally from aclk. */
`timescale 1ns/100ps
module board_pins
(
   // Clock
   input wire        aclk,
   // Pads from block
   input wire [7:0]  port0_pin_out,
   input wire [7:0]  port0_pin_oe,
   input wire [7:0]  port0_pullup_en,
   input wire [4:2]  port1_pin_out,
   input wire [4:2]  port1_pin_oe,
   // Far-end drive
   input wire [10:0] ext_v,
   input wire [10:0] ext_e,
   // Pin levels
   output wire [7:0] port0_pin_in,
   output wire [4:2] port1_pin_in
);
reg tog_r = 1'b0;
always @(posedge aclk)
begin
   tog_r <= ~tog_r;
end
// Undriven pins without a pull-up wander every cycle
assign port0_pin_in = (port0_pin_oe & port0_pin_out) | (~port0_pin_oe & ext_e[7:0] & ext_v[7:0])
   | (~port0_pin_oe & ~ext_e[7:0] & (port0_pullup_en | {8{tog_r}}));
assign port1_pin_in = (port1_pin_oe & port1_pin_out) | (~port1_pin_oe & ext_e[10:8] & ext_v[10:8])
   | (~port1_pin_oe & ~ext_e[10:8] & {3{tog_r}});
endmodule // board_pins

// *** port_pad_mode_pullup_ctrl_test.sv ***
/* Self-checking bench of the pad control block.
 Assumes the board model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`include "port_pad_consts.vh"
module port_pad_mode_pullup_ctrl_test;
reg         aclk = 1'b0, aresetn = 1'b0;
reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, port0_dir_out = 8'h00, v, d, x;
reg  [31:0] wdata = 32'h0;
reg  [3:0]  wstrb = 4'h0;
reg  [4:2]  port1_data = 3'h0;
reg         pwm_four_out = 1'b0, pwm_three_out = 1'b0, buzzer_out = 1'b0;
reg  [10:0] ext_v = 11'h000, ext_e = 11'h7ff;
wire        awready, wready, bvalid, arready, rvalid, ext_irq_nine, ext_irq_eight;
wire        analog_in_eight_sel, analog_in_seven_sel;
wire [1:0]  bresp, rresp;
wire [31:0] rdata;
wire [7:0]  port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup_en;
wire [4:2]  port1_pin_in, port1_pin_out, port1_pin_oe;
integer     err_count = 0, tests_run = 0, cyc = 0, i;
reg  [33:0] exp_r[$];
reg  [1:0]  exp_b[$];

always #2.5 aclk = ~aclk;

port_pad_mode_pullup_ctrl u_dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
   .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
   .rready, .rdata, .rresp, .port0_pin_in, .port0_pin_out, .port0_pin_oe, .port0_pullup_en,
   .port0_dir_out, .port1_pin_in, .port1_pin_out, .port1_pin_oe, .port1_data, .pwm_four_out,
   .pwm_three_out, .buzzer_out, .ext_irq_nine, .ext_irq_eight, .analog_in_eight_sel,
   .analog_in_seven_sel);
board_pins u_board (.aclk, .port0_pin_out, .port0_pin_oe, .port0_pullup_en, .port1_pin_out,
   .port1_pin_oe, .ext_v, .ext_e, .port0_pin_in, .port1_pin_in);

task final_report;
begin
   $display("Checks %0d, errors %0d", tests_run, err_count);
   if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
   else
      $display("Simulation failed");
   $finish;
end
endtask

task chk_bus(input [33:0] e, input [33:0] g);
begin
   tests_run = tests_run + 1;
   if (g !== e)
   begin
      err_count = err_count + 1;
      $display("Error %0t: bus got %h want %h", $time, g, e);
   end
end
endtask

task chk_pin(input [7:0] e, input [7:0] g);
begin
   tests_run = tests_run + 1;
   if (g !== e)
   begin
      err_count = err_count + 1;
      $display("Error %0t: pin got %h want %h", $time, g, e);
   end
end
endtask

// Bus answers against queued notes
always @(posedge aclk)
begin
   cyc = cyc + 1;
   if (rvalid && rready)
      chk_bus(exp_r.pop_front(), {rresp, rdata});
   if (bvalid && bready)
      chk_bus({32'h0, exp_b.pop_front()}, {32'h0, bresp});
   if (cyc == 20000)
   begin
      err_count = err_count + 1;
      final_report;
   end
end

task wr(input [7:0] a, input [7:0] dd, input [3:0] s, input [1:0] r);
   reg ad, wd;
begin
   exp_b.push_back(r);
   @(posedge aclk);
   awaddr <= a;
   wdata <= ($urandom & 32'hffffff00) | {24'h0, dd};
   wstrb <= s;
   awvalid <= 1'b1;
   wvalid <= 1'b1;
   bready <= 1'b1;
   ad = 1'b0;
   wd = 1'b0;
   while (!(ad && wd))
   begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
         awvalid <= 1'b0;
         ad = 1'b1;
      end
      if (wvalid && wready)
      begin
         wvalid <= 1'b0;
         wd = 1'b1;
      end
   end
   while (!bvalid) @(posedge aclk);
   bready <= 1'b0;
end
endtask

task rd(input [7:0] a, input [7:0] e, input [1:0] r);
begin
   exp_r.push_back({r, 24'h0, e});
   @(posedge aclk);
   araddr <= a;
   arvalid <= 1'b1;
   rready <= 1'b1;
   @(posedge aclk);
   while (!arready) @(posedge aclk);
   arvalid <= 1'b0;
   while (!rvalid) @(posedge aclk);
   rready <= 1'b0;
end
endtask

// Expected {oe, out, irq enable, analog} of line 4 (k 0), 3 (k 1) or 2 (k 2)
function [3:0] exp1(input [1:0] k, input [2:0] m, input dd, input alt);
begin
   exp1 = 4'h0;
   if (m == 3'h0)
      exp1[1] = (k != 2'h0);
   else if (m == 3'h1 && k != 2'h2)
      exp1[3] = ~dd;
   else if (m == 3'h2)
      exp1[0] = (k != 2'h0);
   else if ((m == 3'h3 && k != 2'h0) || (m == 3'h5 && k == 2'h2))
      exp1[3:2] = {1'b1, alt};
   else if (m[2] && (m[1:0] == 2'h3 || k == 2'h1))
      exp1[3:2] = {1'b1, dd};
end
endfunction

task p1(input [1:0] k, input [2:0] m);
   integer p;
   reg [3:0] e;
   reg [1:0] s;
begin
   p = 4 - k;
   e = exp1(k, m, port1_data[p], (k == 2'h1) ? pwm_four_out :
       (m == 3'h5) ? buzzer_out : pwm_three_out);
   s = (k == 2'h1) ? {ext_irq_nine, analog_in_eight_sel} :
       (k == 2'h2) ? {ext_irq_eight, analog_in_seven_sel} : 2'b00;
   chk_pin({4'h0, e[3:2], e[1] & port1_pin_in[p], e[0]},
           {4'h0, port1_pin_oe[p], e[3] & port1_pin_out[p], s});
end
endtask

initial
begin
   x = 8'($urandom(32'h2e02));
   repeat (20) @(posedge aclk);
   aresetn <= 1'b1;
   rd(`OFS_P0_PULLUP, `RST_P0_PULLUP, `RESP_OKAY);
   rd(`OFS_P1_TOP_MODE, `RST_P1_TOP_MODE, `RESP_OKAY);
   rd(`OFS_P1_MID_MODE, `RST_P1_MID_MODE, `RESP_OKAY);
   rd(8'h10, 8'h00, `RESP_SLVERR);
   wr(8'h10, 8'h5a, 4'h1, `RESP_SLVERR);
   ext_e <= 11'h700;
   for (i = 0; i < 3; i = i + 1)
   begin
      v = 8'($urandom);
      wr(`OFS_P0_PULLUP, v, 4'h1, `RESP_OKAY);
      #1 chk_pin(v, port0_pullup_en);
      rd(`OFS_P0_PULLUP, v, `RESP_OKAY);
   end
   wr(`OFS_P0_PULLUP, ~v, 4'h0, `RESP_OKAY);
   rd(`OFS_P0_PULLUP, v, `RESP_OKAY);
   for (i = 0; i < 4; i = i + 1)
   begin
      d = 8'($urandom);
      x = 8'($urandom);
      v = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : 8'($urandom);
      port0_dir_out <= v;
      ext_e <= {3'h7, ~v};
      ext_v <= {3'h0, x};
      wr(`OFS_P0_DATA, d, 4'h1, `RESP_OKAY);
      #1 chk_pin(d & v, port0_pin_out);
      chk_pin(v, port0_pin_oe);
      rd(`OFS_P0_DATA, (d & v) | (x & ~v), `RESP_OKAY);
   end
   for (i = 0; i < 64; i = i + 1)
   begin
      x = 8'($urandom);
      port1_data <= x[4:2];
      // Peripheral source levels randomised alongside the mode
      {pwm_four_out, pwm_three_out, buzzer_out} <= x[7:5];
      ext_v <= 11'($urandom);
      wr(`OFS_P1_TOP_MODE, {x[7:2], i[1:0]}, 4'h1, `RESP_OKAY);
      wr(`OFS_P1_MID_MODE, {i[5:0], x[1:0]}, 4'h1, `RESP_OKAY);
      #1 p1(2'h0, {i[1], i[1:0]});
      p1(2'h1, i[5:3]);
      p1(2'h2, i[2:0]);
      rd(`OFS_P1_TOP_MODE, {6'h00, i[1:0]}, `RESP_OKAY);
      rd(`OFS_P1_MID_MODE, {i[5:0], 2'b00}, `RESP_OKAY);
   end
   aresetn <= 1'b0;
   repeat (3) @(posedge aclk);
   aresetn <= 1'b1;
   rd(`OFS_P1_MID_MODE, `RST_P1_MID_MODE, `RESP_OKAY);
   #1 p1(2'h0, 3'h1);
   p1(2'h1, 3'h1);
   p1(2'h2, 3'h0);
   final_report;
end
endmodule // port_pad_mode_pullup_ctrl_test
